//--- logic/flp_regs.svh
/*
 * constants of the flash lock protection block: lock codes,
 * flash region bounds, lock byte locations, ram windows.
 * assumes a 16-bit code address space and 8-bit lock bytes.
 */
`ifndef FLP_REGS_SVH
`define FLP_REGS_SVH

// lock byte codes
`define FLP_LOCK_OPEN 8'hff
`define FLP_UCFG_LOCKED 8'h00
`define FLP_CODE_MIN 8'h80
`define FLP_CODE_FIRST 8'hfe

// main code area: 32 pages of 512 bytes
`define FLP_PAGE_TOP 5'h1f
`define FLP_PAGE_LSB 9
`define FLP_CODE_BASE 16'h0000
`define FLP_CODE_END 16'h3fff

// user configuration and factory sectors
`define FLP_UCFG_BASE 16'h4000
`define FLP_UCFG_END 16'h41ff
`define FLP_FCFG_BASE 16'h4200
`define FLP_FCFG_END 16'h4bff

// lock byte locations, last bytes of their sectors
`define FLP_LB_BU_ADDR 16'h3ffe
`define FLP_LB_TD_ADDR 16'h3fff
`define FLP_LB_UCFG_ADDR 16'h41ff

// volatile ram window in external data space
`define FLP_VOLATILE_EXT_RAM_BASE 16'h0100
`define FLP_VOLATILE_EXT_RAM_END 16'h01ff

// direct accesses at or above this go to special registers
`define FLP_SFR_SPLIT 8'h80

// retention ram last index
`define FLP_RET_LAST 7'h7f

`endif

//--- logic/flp_pkg.sv
/*
 * types of the flash lock protection block.
 * assumes flp_regs.svh for the numeric constants.
 */
package flp_pkg;

    // flash operation codes
    typedef enum logic [1:0] {
        FLP_OP_READ = 2'b00,
        FLP_OP_WRITE = 2'b01,
        FLP_OP_SECT_ERASE = 2'b10,
        FLP_OP_CHIP_ERASE = 2'b11
    } flp_op_e;

    // block sequencer states
    typedef enum logic [1:0] {
        FLP_ST_SAMPLE = 2'b00,
        FLP_ST_CLEAR = 2'b01,
        FLP_ST_RUN = 2'b10
    } flp_state_e;

    // all state of the block except the retention ram
    typedef struct packed {
        flp_state_e state;
        logic [7:0] lock_bu;
        logic [7:0] lock_td;
        logic [7:0] lock_ucfg;
        logic [7:0] lock_fcfg;
        logic [6:0] clr_idx;
        logic ready;
        logic [31:0] pages;
        logic ack;
        logic allow;
        logic [7:0] ret_rdata;
        logic [7:0] xd_rdata;
        logic xd_hit;
        logic to_sfr;
        logic to_internal_data_ram;
        logic [255:0][7:0] volatile_ext_ram;
    } flp_state_s;

endpackage

//--- logic/flp_protect.sv
/*
 * flash lock protection: lock byte sampling, page lock map,
 * per-request allow/deny, retention ram, volatile ram and
 * direct/indirect data address routing.
 * assumes all inputs come from logic on clk_i; lock byte
 * values are presented by the flash array at reset release.
 */
// What this block does
// - lock byte 0xff opens; invalid codes refused
// - lock bytes sampled only after reset
// - factory sectors never overwritten or erased
// - code area: 32 pages of 512 bytes
// - any code lock set locks page 31
// - bottom-up lock grows from page zero
// - config lock 0x00: read yes, write no
// - config lock set by programmer or software
// - normal mode: no chip erase ever
// - code lock: no write; no read programming
// - programming mode: sector erase, line write
// - retention ram cleared on first power-up
// - volatile ram sits in external data space
// - upper data addresses: direct sfr, indirect ram
`timescale 1ns/10ps
`include "flp_regs.svh"

module flp_protect
    import flp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    // lock bytes as stored in flash
    input wire logic [7:0] lock_bu_i,
    input wire logic [7:0] lock_td_i,
    input wire logic [7:0] lock_ucfg_i,
    input wire logic [7:0] lock_fcfg_i,
    input wire logic first_power_up_i,
    // flash access request
    input wire logic prog_mode_i,
    input wire logic req_i,
    input wire logic [1:0] req_op_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic ack_o,
    output logic allow_o,
    output logic ready_o,
    output logic [31:0] locked_pages_o,
    // retention ram port
    input wire logic ret_req_i,
    input wire logic ret_we_i,
    input wire logic [6:0] ret_addr_i,
    input wire logic [7:0] ret_wdata_i,
    output logic [7:0] ret_rdata_o,
    // external data space port
    input wire logic xd_req_i,
    input wire logic xd_we_i,
    input wire logic [15:0] xd_addr_i,
    input wire logic [7:0] xd_wdata_i,
    output logic [7:0] xd_rdata_o,
    output logic xd_hit_o,
    // data address routing
    input wire logic dr_req_i,
    input wire logic dr_indirect_i,
    input wire logic [7:0] dr_addr_i,
    output logic to_sfr_o,
    output logic to_internal_data_ram_o
);

    // bottom-up lock to page map
    function automatic logic [31:0] bu_map(input logic [7:0] v);
        logic [31:0] m;
        logic [7:0] n;
        m = '0;
        n = `FLP_CODE_FIRST - v;
        if (v == `FLP_LOCK_OPEN) begin
            m = '0;
        end else if (v < `FLP_CODE_MIN) begin
            // illegal code: fail safe, lock all
            m = '1;
        end else begin
            for (int p = 0; p < 32; p++) begin
                m[p] = (8'(p) <= n);
            end
        end
        return m;
    endfunction

    // top-down lock to page map
    function automatic logic [31:0] td_map(input logic [7:0] v);
        logic [31:0] m;
        logic [7:0] n;
        m = '0;
        n = `FLP_CODE_FIRST - v;
        if (v == `FLP_LOCK_OPEN) begin
            m = '0;
        end else if (v < `FLP_CODE_MIN) begin
            m = '1;
        end else begin
            for (int p = 0; p < 32; p++) begin
                m[p] = (8'(p) + n >= 8'd31);
            end
        end
        return m;
    endfunction

    // address range test
    function automatic logic in_rng(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // registered and next state
    flp_state_s s_q;
    flp_state_s s_d;
    // retention ram, kept outside the reset state struct
    logic [7:0] ret_mem_q [128];

    // decode helpers
    logic [31:0] map_w; // union of both page maps, plus page 31 when any code lock is set
    logic in_code; // address in main code area
    logic in_ucfg; // address in user config sector
    logic in_fcfg; // address in factory sectors
    logic pg_lock; // addressed page is locked
    logic ucfg_lk; // user config lock active
    logic bad_lb; // illegal lock byte value written
    logic ok; // request permitted
    logic [4:0] page; // addressed page number
    logic [7:0] xd_idx; // volatile ram index

    // page map and access decision
    always_comb begin
        map_w = bu_map(s_q.lock_bu) | td_map(s_q.lock_td);
        if (s_q.lock_bu != `FLP_LOCK_OPEN
            || s_q.lock_td != `FLP_LOCK_OPEN) begin
            map_w[`FLP_PAGE_TOP] = 1'b1;
        end
        in_code = in_rng(req_addr_i, `FLP_CODE_BASE, `FLP_CODE_END);
        in_ucfg = in_rng(req_addr_i, `FLP_UCFG_BASE, `FLP_UCFG_END);
        in_fcfg = in_rng(req_addr_i, `FLP_FCFG_BASE, `FLP_FCFG_END);
        page = req_addr_i[`FLP_PAGE_LSB +: 5];
        pg_lock = map_w[page];
        // anything but open counts as locked
        ucfg_lk = (s_q.lock_ucfg != `FLP_LOCK_OPEN);
        // only documented codes may land in lock bytes
        bad_lb = 1'b0;
        if (req_op_i == FLP_OP_WRITE) begin
            if (req_addr_i == `FLP_LB_BU_ADDR
                || req_addr_i == `FLP_LB_TD_ADDR) begin
                bad_lb = (req_wdata_i < `FLP_CODE_MIN);
            end
            if (req_addr_i == `FLP_LB_UCFG_ADDR) begin
                bad_lb = (req_wdata_i != `FLP_LOCK_OPEN)
                    && (req_wdata_i != `FLP_UCFG_LOCKED);
            end
        end
        ok = 1'b0;
        unique case (flp_op_e'(req_op_i))
            FLP_OP_CHIP_ERASE: begin
                // chip erase only in programming mode
                ok = prog_mode_i;
            end
            FLP_OP_READ: begin
                if (in_code) begin
                    ok = !(pg_lock && prog_mode_i);
                end else if (in_ucfg) begin
                    ok = 1'b1;
                end else if (in_fcfg) begin
                    ok = (s_q.lock_fcfg == `FLP_LOCK_OPEN);
                end else begin
                    ok = 1'b0;
                end
            end
            FLP_OP_WRITE, FLP_OP_SECT_ERASE: begin
                if (in_code) begin
                    ok = !pg_lock;
                end else if (in_ucfg) begin
                    ok = !ucfg_lk;
                end else begin
                    // factory sectors and holes: never
                    ok = 1'b0;
                end
                if (bad_lb) begin
                    ok = 1'b0;
                end
            end
        endcase
        xd_idx = xd_addr_i[7:0];
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.xd_hit = 1'b0;
        s_d.to_sfr = 1'b0;
        s_d.to_internal_data_ram = 1'b0;
        unique case (s_q.state)
            FLP_ST_SAMPLE: begin
                // capture lock bytes once per reset
                s_d.lock_bu = lock_bu_i;
                s_d.lock_td = lock_td_i;
                s_d.lock_ucfg = lock_ucfg_i;
                s_d.lock_fcfg = lock_fcfg_i;
                s_d.clr_idx = '0;
                if (first_power_up_i) begin
                    s_d.state = FLP_ST_CLEAR;
                end else begin
                    s_d.state = FLP_ST_RUN;
                    s_d.ready = 1'b1;
                end
            end
            FLP_ST_CLEAR: begin
                // wipe retention ram a byte per cycle
                // the ram process below does the wiping
                s_d.clr_idx = s_q.clr_idx + 7'h01;
                if (s_q.clr_idx == `FLP_RET_LAST) begin
                    s_d.state = FLP_ST_RUN;
                    s_d.ready = 1'b1;
                end
            end
            FLP_ST_RUN: begin
                // flash requests answered next cycle
                if (req_i) begin
                    s_d.ack = 1'b1;
                    s_d.allow = ok;
                end
                // retention ram kept through all states but FLP_ST_CLEAR
                // writes land in the ram process below
                if (ret_req_i && !ret_we_i) begin
                    s_d.ret_rdata = ret_mem_q[ret_addr_i];
                end
            end
            default: begin
                // illegal code recovers to sampling
                s_d.state = FLP_ST_SAMPLE;
                s_d.ready = 1'b0;
            end
        endcase
        s_d.pages = map_w;
        // volatile ram decoded in external data space
        if (xd_req_i && in_rng(xd_addr_i, `FLP_VOLATILE_EXT_RAM_BASE, `FLP_VOLATILE_EXT_RAM_END)) begin
            s_d.xd_hit = 1'b1;
            if (xd_we_i) begin
                s_d.volatile_ext_ram[xd_idx] = xd_wdata_i;
            end else begin
                s_d.xd_rdata = s_q.volatile_ext_ram[xd_idx];
            end
        end
        // upper half: direct to sfr, indirect to ram
        if (dr_req_i) begin
            s_d.to_sfr = !dr_indirect_i && (dr_addr_i >= `FLP_SFR_SPLIT);
            s_d.to_internal_data_ram = dr_indirect_i || (dr_addr_i < `FLP_SFR_SPLIT);
        end
    end

    // retention ram; no reset on purpose, so that a system
    // reset keeps its contents and only the first power-up
    // sequence wipes it
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            if (s_q.state == FLP_ST_CLEAR) begin
                // wipe a byte per cycle
                ret_mem_q[s_q.clr_idx] <= 8'h00;
            end else if (s_q.state == FLP_ST_RUN && ret_req_i && ret_we_i) begin
                // write kept through reset and sleep
                ret_mem_q[ret_addr_i] <= ret_wdata_i;
            end
        end
    end

    // state register, frozen while en_i is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.lock_bu <= `FLP_LOCK_OPEN;
            s_q.lock_td <= `FLP_LOCK_OPEN;
            s_q.lock_ucfg <= `FLP_LOCK_OPEN;
            s_q.lock_fcfg <= `FLP_LOCK_OPEN;
            s_q.state <= FLP_ST_SAMPLE;
        end else if (en_i) begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign ack_o = s_q.ack;
    assign allow_o = s_q.allow;
    assign ready_o = s_q.ready;
    assign locked_pages_o = s_q.pages;
    assign ret_rdata_o = s_q.ret_rdata;
    assign xd_rdata_o = s_q.xd_rdata;
    assign xd_hit_o = s_q.xd_hit;
    assign to_sfr_o = s_q.to_sfr;
    assign to_internal_data_ram_o = s_q.to_internal_data_ram;

endmodule

//--- tb/flp_protect_checker.sv
/*
 sequence checks on the protection block's ports.
 assumes one clock, async active low reset.
*/
`timescale 1ns/10ps
module flp_protect_checker
    import flp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    // flash request side
    input wire logic prog_mode_i,
    input wire logic req_i,
    input wire logic [1:0] req_op_i,
    input wire logic [15:0] req_addr_i,
    input wire logic ack_o,
    input wire logic allow_o,
    input wire logic ready_o,
    input wire logic [31:0] locked_pages_o,
    // data ports
    input wire logic xd_req_i,
    input wire logic [15:0] xd_addr_i,
    input wire logic xd_hit_o,
    input wire logic dr_req_i,
    input wire logic dr_indirect_i,
    input wire logic [7:0] dr_addr_i,
    input wire logic to_sfr_o,
    input wire logic to_internal_data_ram_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // a request the block must take
    logic tk;
    assign tk = en_i && ready_o && req_i;
    a_req_gets_ack: assert property (tk |=> ack_o) else $error("no ack");
    a_ack_has_cause: assert property (ack_o && $past(en_i) |-> $past(tk))
        else $error("stray ack");
    a_ce_normal_deny: assert property (tk && req_op_i == FLP_OP_CHIP_ERASE && !prog_mode_i
        |=> !allow_o) else $error("chip erase in normal mode");
    a_ce_prog_allow: assert property (tk && req_op_i == FLP_OP_CHIP_ERASE && prog_mode_i
        |=> allow_o) else $error("chip erase refused");
    a_factory_no_wr: assert property (tk && req_op_i inside {FLP_OP_WRITE, FLP_OP_SECT_ERASE}
        && req_addr_i inside {[16'h4200:16'h4bff]} |=> !allow_o)
        else $error("factory sector changed");
    a_page31_locked: assert property (locked_pages_o != 32'h0 |-> locked_pages_o[31])
        else $error("page31 open");
    a_locks_frozen: assert property (ready_o && $past(ready_o) |=> $stable(locked_pages_o))
        else $error("locks moved");
    a_volatile_ext_ram_hit: assert property (en_i && xd_req_i && xd_addr_i inside {[16'h0100:16'h01ff]}
        |=> xd_hit_o) else $error("volatile_ext_ram miss");
    a_sfr_route: assert property (en_i && dr_req_i && !dr_indirect_i && dr_addr_i >= 8'h80
        |=> to_sfr_o && !to_internal_data_ram_o) else $error("direct upper not sfr");
    a_internal_data_ram_route: assert property (en_i && dr_req_i && (dr_indirect_i || dr_addr_i < 8'h80)
        |=> to_internal_data_ram_o && !to_sfr_o) else $error("not ram");
endmodule

//--- tb/flp_prog_host.sv
/*
 programmer side model: holds the lock bytes as stored in
 flash, updated by permitted line writes at lock locations.
 assumes requests come from the bench; survives dut reset.
*/
`timescale 1ns/10ps
module flp_prog_host (
    // watched request
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [1:0] req_op_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic ack_o,
    input wire logic allow_o,
    // stored lock bytes
    output logic [7:0] lock_bu_o,
    output logic [7:0] lock_td_o,
    output logic [7:0] lock_ucfg_o,
    output logic [7:0] lock_fcfg_o
);
    logic [15:0] pa;
    logic [7:0] pd;
    logic pw;
    // erased flash; factory lock set at the factory
    initial begin
        {lock_bu_o, lock_td_o, lock_ucfg_o} = 24'hffffff;
        lock_fcfg_o = 8'h00;
    end
    // line data carries lock values; code locks written last
    always @(posedge clk_i) begin
        if (ack_o && allow_o && pw) begin
            if (pa == 16'h3ffe) lock_bu_o <= pd;
            if (pa == 16'h3fff) lock_td_o <= pd;
            if (pa == 16'h41ff) lock_ucfg_o <= pd;
        end
        pw <= req_i && req_op_i == 2'b01;
        pa <= req_addr_i;
        pd <= req_wdata_i;
    end
endmodule

//--- tb/tb_top.sv
/*
 directed bench for the protection block.
 assumes 50 MHz clock, inputs driven 1 ns after rising edge.
*/
`timescale 1ns/10ps
module tb_top;
    import flp_pkg::*;
    logic clk_i = 0, rstn_i = 0, en_i = 1, fp = 0, prog_mode_i = 0;
    logic req_i = 0, ret_req_i = 0, ret_we_i = 0, xd_req_i = 0, xd_we_i = 0;
    logic dr_req_i = 0, dr_indirect_i = 0, ack_o, allow_o, ready_o;
    logic xd_hit_o, to_sfr_o, to_internal_data_ram_o;
    logic [1:0] req_op_i = 0;
    logic [15:0] req_addr_i = 0, xd_addr_i = 0;
    logic [7:0] req_wdata_i = 0, ret_wdata_i = 0, xd_wdata_i = 0, dr_addr_i = 0;
    logic [7:0] ret_rdata_o, xd_rdata_o, lbu, ltd, luc, lfc;
    logic [6:0] ret_addr_i = 0;
    logic [31:0] locked_pages_o;
    int miscompares = 0, checked = 0;
    initial forever #10 clk_i = ~clk_i;
    flp_prog_host host (.clk_i(clk_i), .req_i(req_i), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ack_o(ack_o),
        .allow_o(allow_o), .lock_bu_o(lbu), .lock_td_o(ltd), .lock_ucfg_o(luc),
        .lock_fcfg_o(lfc));
    flp_protect dut (.clk_i, .rstn_i, .en_i, .lock_bu_i(lbu), .lock_td_i(ltd),
        .lock_ucfg_i(luc), .lock_fcfg_i(lfc), .first_power_up_i(fp), .prog_mode_i,
        .req_i, .req_op_i, .req_addr_i, .req_wdata_i, .ack_o, .allow_o, .ready_o,
        .locked_pages_o, .ret_req_i, .ret_we_i, .ret_addr_i, .ret_wdata_i,
        .ret_rdata_o, .xd_req_i, .xd_we_i, .xd_addr_i, .xd_wdata_i, .xd_rdata_o,
        .xd_hit_o, .dr_req_i, .dr_indirect_i, .dr_addr_i, .to_sfr_o, .to_internal_data_ram_o);
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // reset, then wait for lock sampling to finish
    task automatic boot(input logic f);
        // let a pending answer reach the host before reset
        @(posedge clk_i) #1 rstn_i = 0;
        fp = f;
        repeat (3) @(posedge clk_i);
        #1 rstn_i = 1;
        for (int i = 0; i < 200 && ready_o !== 1'b1; i++) @(posedge clk_i) #1;
        chk(ready_o, 1);
    endtask
    // one flash request, answer checked one cycle later
    task automatic rq(input flp_op_e op, input logic [15:0] a, input logic [7:0] d,
        input logic ex);
        @(posedge clk_i) #1;
        {req_i, req_op_i, req_addr_i, req_wdata_i} = {1'b1, op, a, d};
        @(posedge clk_i) #1 req_i = 0;
        chk(ack_o, 1);
        chk(allow_o, ex);
    endtask
    // one strobe on the retention or external data port
    task automatic mem(input logic x, input logic w, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge clk_i) #1;
        {ret_we_i, ret_addr_i, ret_wdata_i} = {w, a[6:0], d};
        {xd_we_i, xd_addr_i, xd_wdata_i} = {w, a, d};
        {xd_req_i, ret_req_i} = {x, !x};
        @(posedge clk_i) #1 {xd_req_i, ret_req_i} = 2'b00;
    endtask
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        boot(0);
        chk(locked_pages_o, 32'h0);
        rq(FLP_OP_CHIP_ERASE, 16'h0000, 8'h00, 0);
        rq(FLP_OP_WRITE, 16'h0200, 8'h12, 1);
        rq(FLP_OP_SECT_ERASE, 16'h4000, 8'h00, 1);
        rq(FLP_OP_SECT_ERASE, 16'h4200, 8'h00, 0);
        rq(FLP_OP_WRITE, 16'h4bff, 8'h00, 0);
        prog_mode_i = 1;
        rq(FLP_OP_CHIP_ERASE, 16'h0000, 8'h00, 1);
        rq(FLP_OP_WRITE, 16'h3ffe, 8'h7f, 0);
        rq(FLP_OP_WRITE, 16'h41ff, 8'h00, 1);
        rq(FLP_OP_WRITE, 16'h3ffe, 8'hfe, 1);
        rq(FLP_OP_WRITE, 16'h3fff, 8'hfd, 1);
        chk(locked_pages_o, 32'h0);
        boot(1);
        chk(locked_pages_o, 32'hc0000001);
        rq(FLP_OP_READ, 16'h0000, 8'h00, 0);
        rq(FLP_OP_READ, 16'h0a00, 8'h00, 1);
        rq(FLP_OP_WRITE, 16'h3c00, 8'h00, 0);
        rq(FLP_OP_WRITE, 16'h0200, 8'h00, 1);
        rq(FLP_OP_WRITE, 16'h4010, 8'h00, 0);
        rq(FLP_OP_READ, 16'h4010, 8'h00, 1);
        prog_mode_i = 0;
        rq(FLP_OP_READ, 16'h0000, 8'h00, 1);
        rq(FLP_OP_SECT_ERASE, 16'h4000, 8'h00, 0);
        mem(0, 0, 16'h0005, 8'h00);
        chk(ret_rdata_o, 8'h00);
        mem(0, 1, 16'h0005, 8'ha5);
        mem(0, 0, 16'h0005, 8'h00);
        chk(ret_rdata_o, 8'ha5);
        mem(1, 1, 16'h0150, 8'h3c);
        mem(1, 0, 16'h0150, 8'h00);
        chk({xd_hit_o, xd_rdata_o}, 9'h13c);
        mem(1, 0, 16'h0050, 8'h00);
        chk(xd_hit_o, 0);
        // frozen clock enable: a request is not taken
        @(posedge clk_i) #1 {en_i, req_i} = 2'b01;
        @(posedge clk_i) #1 chk(ack_o, 0);
        {en_i, req_i} = 2'b10;
        // direct upper, indirect upper, direct lower
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i) #1;
            {dr_req_i, dr_indirect_i, dr_addr_i} = {1'b1, k == 1, k == 2 ? 8'h7f : 8'h80};
            @(posedge clk_i) #1 dr_req_i = 0;
            chk({to_sfr_o, to_internal_data_ram_o}, k == 0 ? 2'b10 : 2'b01);
        end
        // retention ram survives a later system reset
        boot(0);
        mem(0, 0, 16'h0005, 8'h00);
        chk(ret_rdata_o, 8'ha5);
        end_sim();
    end
endmodule
bind flp_protect flp_protect_checker chk (.*);
